//--- rtl/sbt_pkg.sv
// Constants, register map and state types for the standstill and brake timer.
// Assumes one 200 MHz clock and a parameter port driven by the drive's firmware.
// Behaviour
// RL1: After a move ends, the done flag rises once the deviation has stayed in the window for the whole dwell time.
// RL2: A dwell time of zero turns standstill monitoring off; otherwise it is up to 32767 ms.
// RL3: Standstill counts only while the absolute deviation is at or below the window size (0 to 32767 raw units).
// RL4: An error is flagged if the window is not reached within the timeout in ms; zero turns the check off.
// RL5: The timeout starts when the setpoint reaches target or the profile generator finishes.
// RL6: On amplifier enable the drive's response is held off for the release delay after the brake opens, up to 1000 ms.
// RL7: On amplifier disable the brake is applied and the motor stays energised for the apply delay, default 0, max 1000 ms.
// The code cuts power at once when the disable comes during the release delay.
// RL8: The brake release drives the brake controller only through the output assigned to that function.
// With no output assigned the code drives the brake from the amplifier-active output instead.
// RL9: In the legacy mode the brake controller is driven from the amplifier-active output directly.
// RL10: With voltage reduction on, the brake controller lowers its brake voltage some time after release.
// RL11: At power-up the brake controller resets, leaves the brake unpowered and its indicator off.
// RL12: All ms delays use one 1 ms tick from the system clock, and each timer restarts when its start recurs.
package sbt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock and tick
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (parameter addresses)
   localparam logic [15:0] OFS_RELEASE_DELAY = 16'h050E;
   localparam logic [15:0] OFS_APPLY_DELAY = 16'h0510;
   localparam logic [15:0] OFS_WINDOW_SIZE = 16'h1112;
   localparam logic [15:0] OFS_DWELL_TIME = 16'h1114;
   localparam logic [15:0] OFS_TIMEOUT = 16'h1116;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and limits
   localparam logic [15:0] RST_RELEASE_DELAY = 16'h0000;
   localparam logic [15:0] RST_APPLY_DELAY = 16'h0000;
   localparam logic [31:0] RST_WINDOW_SIZE = 32'h0000_0190;
   localparam logic [15:0] RST_DWELL_TIME = 16'h0000;
   localparam logic [15:0] RST_TIMEOUT = 16'h0000;
   localparam logic [15:0] MAX_BRAKE_MS = 16'h03E8;
   localparam logic [15:0] MAX_DWELL_MS = 16'h7FFF;
   localparam logic [15:0] MAX_TIMEOUT_MS = 16'h3E80;
   localparam logic [31:0] MAX_WINDOW = 32'h0000_7FFF;

   ////////////////////////////////////////////////////////////////////////
   // States
   typedef enum logic [1:0] {WS_IDLE, WS_WAIT, WS_DONE} sbt_win_e;
   typedef enum logic [2:0] {BS_OFF, BS_RELEASING, BS_ON, BS_APPLYING} sbt_brk_e;

   // Saturating clamp of a 16 bit setting
   function automatic logic [15:0] sbt_clamp16(input logic [15:0] v, input logic [15:0] lim);
      return (v > lim) ? lim : v;
   endfunction

endpackage

//--- rtl/sbt_tick_if.sv
// Carrier of the shared millisecond tick between the top and its timers.
// Assumes a single clock domain.
interface sbt_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface

//--- rtl/sbt_ms_timer.sv
// Millisecond down-counter used by every delay in the block.
// Assumes the tick is a one-cycle pulse on the same clock.
module sbt_ms_timer
   import sbt_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Tick
   sbt_tick_if.dst tick_if,
   // Control
   input wire logic start_in,
   input wire logic [15:0] ms_in,
   output logic expired_out
);

   logic [15:0] cnt_q;
   logic run_q;

   ////////////////////////////////////////////////////////////////////////
   // Restart whenever start recurs; zero expires at once
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_q <= 16'h0000;
         run_q <= 1'b0;
         expired_out <= 1'b0;
      end else if (start_in) begin // RL12
         cnt_q <= ms_in;
         run_q <= (ms_in != 16'h0000);
         expired_out <= (ms_in == 16'h0000);
      end else if (run_q && tick_if.tick) begin
         // First tick may be partial: up to 1 ms early, accepted
         cnt_q <= cnt_q - 16'h0001;
         if (cnt_q == 16'h0001) begin
            run_q <= 1'b0;
            expired_out <= 1'b1;
         end
      end
   end

endmodule

//--- rtl/sbt_top.sv
// Standstill window monitor and holding brake sequencer.
// Assumes parameter writes on a simple address/data port from firmware,
// deviation and control inputs from logic on the same clock.
module sbt_top
   import sbt_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
)(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Parameter port
   input wire logic par_wr_in,
   input wire logic par_rd_in,
   input wire logic [15:0] par_addr_in,
   input wire logic [31:0] par_wdata_in,
   output logic [31:0] par_rdata_out,
   output logic par_err_out,
   // Position loop
   input wire logic signed [31:0] deviation_in,
   input wire logic target_reached_in,
   input wire logic profile_done_in,
   output logic motion_done_out,
   output logic window_error_out,
   // Amplifier and brake
   input wire logic amp_enable_in,
   input wire logic legacy_brake_in,
   input wire logic brake_assigned_in,
   output logic amp_power_out,
   output logic drive_ready_out,
   output logic brake_release_out,
   output logic amplifier_active_output
);

   // A divider below two could never produce a single-cycle tick
   if (TICK_DIV < 2) begin : g_div_check
      $error("TICK_DIV too small");
   end

   sbt_tick_if tick_if ();
   logic [31:0] div_q;
   logic [31:0] window_size_q;
   logic [15:0] dwell_q, tout_q, rel_q, app_q;
   sbt_win_e win_q;
   sbt_brk_e brk_q;
   logic move_end, in_win, dwell_done, tout_done, rel_done, app_done;
   logic dwell_start, tout_start, rel_start, app_start;
   logic amp_q;
   logic brake_cmd;
   logic [31:0] dev_abs;

   ////////////////////////////////////////////////////////////////////////
   // Millisecond tick divider
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         div_q <= 32'h0000_0000;
         tick_if.tick <= 1'b0;
      end else begin
         tick_if.tick <= (div_q == TICK_DIV - 1); // RL12
         div_q <= (div_q == TICK_DIV - 1) ? 32'h0000_0000 : div_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parameter writes; window saturates on the full word, other settings saturate their low 16 bits
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rel_q <= RST_RELEASE_DELAY;
         app_q <= RST_APPLY_DELAY;
         window_size_q <= RST_WINDOW_SIZE;
         dwell_q <= RST_DWELL_TIME;
         tout_q <= RST_TIMEOUT;
      end else if (par_wr_in) begin
         unique case (par_addr_in)
            OFS_RELEASE_DELAY: rel_q <= sbt_clamp16(par_wdata_in[15:0], MAX_BRAKE_MS); // RL6
            OFS_APPLY_DELAY: app_q <= sbt_clamp16(par_wdata_in[15:0], MAX_BRAKE_MS); // RL7
            OFS_WINDOW_SIZE: window_size_q <= (par_wdata_in > MAX_WINDOW) ? MAX_WINDOW : par_wdata_in; // RL3
            OFS_DWELL_TIME: dwell_q <= sbt_clamp16(par_wdata_in[15:0], MAX_DWELL_MS); // RL2
            OFS_TIMEOUT: tout_q <= sbt_clamp16(par_wdata_in[15:0], MAX_TIMEOUT_MS); // RL4
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reads, one cycle latency; unmapped address flags an error
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         par_rdata_out <= 32'h0000_0000;
         par_err_out <= 1'b0;
      end else begin
         par_err_out <= 1'b0;
         if (par_rd_in || par_wr_in) begin
            par_rdata_out <= 32'h0000_0000;
            unique case (par_addr_in)
               OFS_RELEASE_DELAY: par_rdata_out <= {16'h0000, rel_q};
               OFS_APPLY_DELAY: par_rdata_out <= {16'h0000, app_q};
               OFS_WINDOW_SIZE: par_rdata_out <= window_size_q;
               OFS_DWELL_TIME: par_rdata_out <= {16'h0000, dwell_q};
               OFS_TIMEOUT: par_rdata_out <= {16'h0000, tout_q};
               default: par_err_out <= 1'b1;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Window test on the absolute deviation
   assign dev_abs = deviation_in[31] ? 32'(-deviation_in) : deviation_in;
   assign in_win = (dev_abs <= window_size_q); // RL3
   assign move_end = target_reached_in || profile_done_in; // RL5

   // Every move end restarts both timers, even mid-wait or after a result;
   // while waiting, the dwell also restarts whenever the deviation leaves the window
   assign dwell_start = move_end || ((win_q == WS_WAIT) && !in_win); // RL12
   assign tout_start = move_end; // RL5 RL12

   sbt_ms_timer u_dwell (.clk_in(clk_in), .rst_n_in(rst_n_in), .tick_if(tick_if),
      .start_in(dwell_start), .ms_in(dwell_q), .expired_out(dwell_done));
   sbt_ms_timer u_tout (.clk_in(clk_in), .rst_n_in(rst_n_in), .tick_if(tick_if),
      .start_in(tout_start), .ms_in(tout_q), .expired_out(tout_done));

   ////////////////////////////////////////////////////////////////////////
   // Standstill sequence
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         win_q <= WS_IDLE;
         motion_done_out <= 1'b0;
         window_error_out <= 1'b0;
      end else begin
         unique case (win_q)
            WS_IDLE: begin
               if (move_end && dwell_q != 16'h0000) begin // RL2
                  win_q <= WS_WAIT;
                  motion_done_out <= 1'b0;
                  window_error_out <= 1'b0;
               end
            end
            WS_WAIT: begin
               if (in_win && dwell_done && !dwell_start) begin
                  motion_done_out <= 1'b1; // RL1
                  win_q <= WS_DONE;
               end else if (tout_q != 16'h0000 && tout_done && !tout_start) begin
                  window_error_out <= 1'b1; // RL4
                  win_q <= WS_DONE;
               end
            end
            WS_DONE: begin
               // A new move end rearms both timers
               if (move_end) begin
                  // Skip idle so a single move-end pulse starts the next wait
                  win_q <= (dwell_q != 16'h0000) ? WS_WAIT : WS_IDLE; // RL2
                  motion_done_out <= 1'b0;
                  window_error_out <= 1'b0;
               end
            end
            default: win_q <= WS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Brake sequencer
   assign rel_start = (brk_q == BS_OFF) && amp_enable_in;
   assign app_start = (brk_q == BS_ON) && !amp_enable_in;

   sbt_ms_timer u_rel (.clk_in(clk_in), .rst_n_in(rst_n_in), .tick_if(tick_if),
      .start_in(rel_start), .ms_in(rel_q), .expired_out(rel_done));
   sbt_ms_timer u_app (.clk_in(clk_in), .rst_n_in(rst_n_in), .tick_if(tick_if),
      .start_in(app_start), .ms_in(app_q), .expired_out(app_done));

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         brk_q <= BS_OFF;
         amp_q <= 1'b0;
         drive_ready_out <= 1'b0;
      end else begin
         unique case (brk_q)
            BS_OFF: if (amp_enable_in) begin
               brk_q <= BS_RELEASING;
               amp_q <= 1'b1; // Brake opens with power
            end
            BS_RELEASING: begin
               if (!amp_enable_in) begin
                  brk_q <= BS_OFF;
                  amp_q <= 1'b0;
               end else if (rel_done && !rel_start) begin
                  brk_q <= BS_ON;
                  drive_ready_out <= 1'b1; // RL6
               end
            end
            BS_ON: if (!amp_enable_in) begin
               brk_q <= BS_APPLYING;
               drive_ready_out <= 1'b0;
            end
            BS_APPLYING: if (app_done && !app_start) begin
               brk_q <= BS_OFF;
               amp_q <= 1'b0; // RL7
            end
            default: brk_q <= BS_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Brake is applied as soon as the disable is seen; from BS_ON power stays through the apply delay, from BS_RELEASING it drops at once
   assign brake_cmd = amp_q && (brk_q != BS_APPLYING); // RL7

   // Output routing: assigned output, or direct drive on the active output in legacy mode or with none assigned
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         amp_power_out <= 1'b0;
         brake_release_out <= 1'b0;
         amplifier_active_output <= 1'b0;
      end else begin
         amp_power_out <= amp_q;
         brake_release_out <= !legacy_brake_in && brake_assigned_in && brake_cmd; // RL8
         // Legacy or no output assigned: the active output carries the brake command
         amplifier_active_output <= brake_cmd && (legacy_brake_in || !brake_assigned_in); // RL9
      end
   end

endmodule

//--- tb/sbt_assertions.sv
// Checker for the standstill and brake timer, bound to its top module.
// Assumes one clock and a synchronous active-low reset at the top.
module sbt_assertions
   import sbt_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
)(
   // Clock, reset and parameter writes
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic par_wr_in,
   input wire logic [15:0] par_addr_in,
   input wire logic [31:0] par_wdata_in,
   // Position loop and brake
   input wire logic signed [31:0] deviation_in,
   input wire logic amp_enable_in,
   input wire logic legacy_brake_in,
   input wire logic brake_assigned_in,
   input wire logic motion_done_out,
   input wire logic window_error_out,
   input wire logic amp_power_out,
   input wire logic drive_ready_out,
   input wire logic brake_release_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] win_q, in_cnt_q, en_cnt_q, dev_abs;
   logic [15:0] dwell_q, rel_q, apl_q;
   assign dev_abs = deviation_in[31] ? -deviation_in : deviation_in;
   // Shadow settings; bench only writes in-range values after the limit test
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         win_q <= RST_WINDOW_SIZE;
         dwell_q <= RST_DWELL_TIME;
         rel_q <= RST_RELEASE_DELAY;
         apl_q <= RST_APPLY_DELAY;
      end else if (par_wr_in) begin
         if (par_addr_in == OFS_WINDOW_SIZE) win_q <= par_wdata_in;
         if (par_addr_in == OFS_DWELL_TIME) dwell_q <= par_wdata_in[15:0];
         if (par_addr_in == OFS_RELEASE_DELAY) rel_q <= par_wdata_in[15:0];
         if (par_addr_in == OFS_APPLY_DELAY) apl_q <= par_wdata_in[15:0];
      end
   end
   // Cycles inside the window and with the enable held
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         in_cnt_q <= 32'h0;
         en_cnt_q <= 32'h0;
      end else begin
         in_cnt_q <= (dev_abs <= win_q) ? in_cnt_q + 32'h1 : 32'h0;
         en_cnt_q <= amp_enable_in ? en_cnt_q + 32'h1 : 32'h0;
      end
   end
   //////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_enable_held;
      $rose(amp_enable_in) ##1 amp_enable_in;
   endsequence
   sequence s_off_after_ready;
      $fell(amp_enable_in) && drive_ready_out && apl_q >= 16'h2;
   endsequence
   a_done_after_dwell: assert property ($rose(motion_done_out) |-> in_cnt_q + TICK_DIV >= dwell_q * TICK_DIV)
      else $error("done rose before the dwell time");
   a_dwell_zero_off: assert property (dwell_q == 16'h0 |-> !$rose(motion_done_out))
      else $error("done rose with monitoring off");
   a_error_not_done: assert property ($rose(window_error_out) |-> !motion_done_out)
      else $error("error raised after standstill");
   a_power_two_cycles: assert property (s_enable_held |=> amp_power_out)
      else $error("power late after enable");
   a_ready_after_delay: assert property ($rose(drive_ready_out) |-> en_cnt_q + TICK_DIV >= rel_q * TICK_DIV)
      else $error("ready before the release delay");
   a_ready_needs_power: assert property (drive_ready_out |-> amp_power_out)
      else $error("ready without power");
   a_ready_drops: assert property ($fell(amp_enable_in) |-> ##[1:2] !drive_ready_out)
      else $error("ready held after disable");
   a_power_held_apply: assert property (s_off_after_ready |-> amp_power_out [*8])
      else $error("power cut before apply delay");
   a_brake_route: assert property (brake_release_out |-> $past(brake_assigned_in) && !$past(legacy_brake_in))
      else $error("brake output used while not assigned");
   a_brake_applies: assert property ($fell(amp_enable_in) && drive_ready_out |-> ##[1:2] !brake_release_out)
      else $error("brake still released after disable");
endmodule
bind sbt_top sbt_assertions #(.TICK_DIV(TICK_DIV)) u_sbt_assertions (.clk_in, .rst_n_in, .par_wr_in, .par_addr_in,
   .par_wdata_in, .deviation_in, .amp_enable_in, .legacy_brake_in, .brake_assigned_in, .motion_done_out,
   .window_error_out, .amp_power_out, .drive_ready_out, .brake_release_out);

//--- tb/sbt_far_side.sv
// Behavioural far side: a settling position loop and a holding brake controller.
// Assumes the bench clock and a millisecond of MS_CYCLES clocks.
module sbt_far_side #(
   parameter int unsigned MS_CYCLES = 10
)(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Position loop
   input wire logic move_in,
   input wire logic signed [31:0] dev_start_in,
   output logic target_reached_out,
   output logic signed [31:0] deviation_out,
   // Brake controller
   input wire logic brake_cmd_in,
   output logic brake_open_out,
   output logic reduced_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned ms_cnt, open_cnt;
   // Deviation halves each ms, like a loop settling on target
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ms_cnt <= 0;
         target_reached_out <= 1'b0;
         deviation_out <= 32'sh0;
      end else begin
         ms_cnt <= (ms_cnt == MS_CYCLES - 1) ? 0 : ms_cnt + 1;
         target_reached_out <= move_in;
         if (move_in) deviation_out <= dev_start_in;
         else if (ms_cnt == MS_CYCLES - 1) deviation_out <= deviation_out >>> 1;
      end
   end
   // Brake follows its command; voltage drops two ms after release
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         brake_open_out <= 1'b0;
         open_cnt <= 0;
         reduced_out <= 1'b0;
      end else begin
         brake_open_out <= brake_cmd_in;
         open_cnt <= brake_cmd_in ? open_cnt + 1 : 0;
         reduced_out <= brake_cmd_in && open_cnt >= 2 * MS_CYCLES;
      end
   end
endmodule

//--- tb/standstill_and_brake_timing_bench.sv
// Self-checking bench for the standstill and brake timer with its far side.
// Assumes a ten-clock millisecond tick so every delay stays short.
module standstill_and_brake_timing_bench
   import sbt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 10;
   logic clk_in = 1'b0, rst_n_in = 1'b0, par_wr_in = 1'b0, par_rd_in = 1'b0, profile_done_in = 1'b0, look = 1'b0;
   logic amp_enable_in = 1'b0, legacy_brake_in = 1'b0, brake_assigned_in = 1'b1, move = 1'b0;
   logic [15:0] par_addr_in = 16'h0;
   logic [31:0] par_wdata_in = 32'h0, errs = 32'h0, par_rdata_out, stat, v;
   logic signed [31:0] deviation, dev_start = 32'sh0;
   logic par_err_out, motion_done_out, window_error_out, amp_power_out, drive_ready_out, brake_release_out;
   logic amplifier_active_output, target_reached, brake_open, reduced, brake_line;
   logic [15:0] ofs[5] = '{OFS_RELEASE_DELAY, OFS_APPLY_DELAY, OFS_WINDOW_SIZE, OFS_DWELL_TIME, OFS_TIMEOUT};
   logic [31:0] lim[5] = '{MAX_BRAKE_MS, MAX_BRAKE_MS, MAX_WINDOW, MAX_DWELL_MS, MAX_TIMEOUT_MS};
   logic [31:0] rst[5] = '{RST_RELEASE_DELAY, RST_APPLY_DELAY, RST_WINDOW_SIZE, RST_DWELL_TIME, RST_TIMEOUT};
   logic [31:0] exps[$];
   int kinds[$], fail_count = 0, checks = 0, k;
   sbt_top #(.TICK_DIV(MS)) u_dut (.clk_in, .rst_n_in, .par_wr_in, .par_rd_in, .par_addr_in, .par_wdata_in,
      .par_rdata_out, .par_err_out, .deviation_in(deviation), .target_reached_in(target_reached), .profile_done_in,
      .motion_done_out, .window_error_out, .amp_enable_in, .legacy_brake_in, .brake_assigned_in, .amp_power_out,
      .drive_ready_out, .brake_release_out, .amplifier_active_output);
   sbt_far_side #(.MS_CYCLES(MS)) u_far (.clk_in, .rst_n_in, .move_in(move), .dev_start_in(dev_start),
      .target_reached_out(target_reached), .deviation_out(deviation), .brake_cmd_in(brake_line),
      .brake_open_out(brake_open), .reduced_out(reduced));
   // Brake controller sits on whichever output carries the function
   assign brake_line = (legacy_brake_in || !brake_assigned_in) ? amplifier_active_output : brake_release_out;
   assign stat = {25'h0, motion_done_out, window_error_out, amp_power_out, drive_ready_out, brake_release_out,
      brake_open, reduced};
   always #2.5 clk_in = ~clk_in;
   // Error pulses last one cycle, so they are counted as they pass
   always @(posedge clk_in) if (par_err_out === 1'b1) errs <= errs + 32'h1;
   //////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Observer: takes the oldest note whenever a sample falls due
   always @(negedge clk_in) begin
      if (look) begin
         k = kinds.pop_front();
         case (k)
            0: check(par_rdata_out, exps.pop_front());
            1: check(stat, exps.pop_front());
            2: check({31'h0, amplifier_active_output}, exps.pop_front());
            default: check(errs, exps.pop_front());
         endcase
      end
   end
   task automatic note(input int kd, input logic [31:0] e);
      kinds.push_back(kd);
      exps.push_back(e);
      @(posedge clk_in) look <= 1'b1;
      @(posedge clk_in) look <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_in);
      par_wr_in <= 1'b1;
      par_addr_in <= a;
      par_wdata_in <= d;
      @(posedge clk_in) par_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge clk_in);
      par_rd_in <= 1'b1;
      par_addr_in <= a;
      @(posedge clk_in) par_rd_in <= 1'b0;
      note(0, e);
   endtask
   task automatic mv(input logic signed [31:0] d, input logic prof);
      @(posedge clk_in);
      move <= 1'b1;
      dev_start <= d;
      profile_done_in <= prof;
      @(posedge clk_in);
      move <= 1'b0;
      profile_done_in <= 1'b0;
   endtask
   // Bounded wait; the time taken must fall inside lo..hi cycles
   task automatic wait_lv(ref logic s, input logic lv, input int lo, input int hi);
      int n;
      n = 0;
      while (s !== lv && n <= hi) begin
         @(posedge clk_in);
         n++;
      end
      check(n >= lo && n <= hi, 32'h1);
   endtask
   //////////////////////////////////////////////////
   initial begin
      v = $urandom(32'hD0F09AB4);
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      foreach (ofs[i]) rd(ofs[i], rst[i]);
      rd(16'h0, 32'h0);
      note(3, 32'h1);
      $display("test reset values done");
      foreach (ofs[i]) begin
         v = $urandom % (lim[i] + 32'h1);
         wr(ofs[i], v);
         rd(ofs[i], v);
         wr(ofs[i], lim[i] + 32'h1 + $urandom % 50);
         rd(ofs[i], lim[i]);
      end
      wr(16'h0512, 32'h5);
      note(3, 32'h2);
      rd(OFS_APPLY_DELAY, MAX_BRAKE_MS);
      $display("test register access done");
      wr(OFS_DWELL_TIME, 32'h0);
      wr(OFS_TIMEOUT, 32'h2);
      wr(OFS_WINDOW_SIZE, 32'h64);
      mv(32'sh3E8, 1'b0);
      repeat (6 * MS) @(posedge clk_in);
      note(1, 32'h0);
      wr(OFS_DWELL_TIME, 32'h3);
      wr(OFS_TIMEOUT, 32'h0);
      mv(32'sh3E8, 1'b0);
      wait_lv(motion_done_out, 1'b1, 4 * MS + 5, 8 * MS);
      note(1, 32'h40);
      wr(OFS_TIMEOUT, 32'h5);
      mv(32'shC000_0000, 1'b1);
      wait_lv(window_error_out, 1'b1, 3 * MS + 5, 6 * MS + 5);
      note(1, 32'h20);
      $display("test standstill done");
      wr(OFS_RELEASE_DELAY, 32'h4);
      wr(OFS_APPLY_DELAY, 32'h3);
      @(posedge clk_in) amp_enable_in <= 1'b1;
      wait_lv(drive_ready_out, 1'b1, 3 * MS, 4 * MS + 8);
      note(1, 32'h3F);
      @(posedge clk_in) amp_enable_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      note(1, 32'h30);
      wait_lv(amp_power_out, 1'b0, 2 * MS - 8, 3 * MS + 6);
      note(1, 32'h20);
      for (int m = 0; m < 2; m++) begin
         legacy_brake_in <= (m == 0);
         brake_assigned_in <= (m == 0);
         wr(OFS_RELEASE_DELAY, 32'h0);
         @(posedge clk_in) amp_enable_in <= 1'b1;
         wait_lv(drive_ready_out, 1'b1, 0, MS);
         note(1, 32'h3A);
         note(2, 32'h1);
         @(posedge clk_in) amp_enable_in <= 1'b0;
         wait_lv(amp_power_out, 1'b0, 2 * MS - 4, 3 * MS + 6);
      end
      legacy_brake_in <= 1'b0;
      brake_assigned_in <= 1'b1;
      wr(OFS_RELEASE_DELAY, 32'hA);
      @(posedge clk_in) amp_enable_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      amp_enable_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      note(1, 32'h20);
      $display("test brake sequencing done");
      results();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #200_000;
      fail_count++;
      results();
   end
endmodule
